// ===== sad_pkg.sv
// system address decoder: address map, bus codes and field helpers
`default_nettype none
package sad_pkg;
  // ==========================================
  // slave indices
  localparam int NSLV = 13;
  localparam int NSLOT = 17;
  localparam int NAPB = 12;
  localparam int S_FLASH = 0;
  localparam int S_BOOT = 1;
  localparam int S_SRAM = 2;
  localparam int S_APB1 = 3;
  localparam int S_APB2 = 4;
  localparam int S_APB3 = 5;
  localparam int S_APB4 = 6;
  localparam int S_FLASHCTL = 7;
  localparam int S_CRC = 8;
  localparam int S_PORT_A = 9;
  localparam int S_PORT_B = 10;
  localparam int S_PORT_C = 11;
  localparam int S_CORE = 12;

  // ==========================================
  // memory regions, inclusive bounds
  localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] FLASH_LAST = 32'h0000_4fff;
  localparam logic [31:0] BOOT_BASE = 32'h0010_0000;
  localparam logic [31:0] BOOT_LAST = 32'h0010_09ff;
  localparam logic [31:0] OTP_BASE = 32'h0010_0770;
  localparam logic [31:0] OTP_LAST = 32'h0010_0785;
  localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] SRAM_LAST = 32'h2000_0bff;
  localparam logic [31:0] CORE_BASE = 32'he000_0000;
  localparam logic [31:0] CORE_LAST = 32'he00f_ffff;

  // ==========================================
  // 1KB peripheral slots: apb devices first, then ahb devices
  localparam int SLOT_LSB = 10;
  localparam logic [31:0] SLOT_BASE [NSLOT] = '{
    32'h4000_0400, 32'h4000_2c00, 32'h4000_3000, 32'h4000_4400,
    32'h4000_5400, 32'h4001_0000, 32'h4001_2400, 32'h4001_2800,
    32'h4001_2c00, 32'h4001_3000, 32'h4001_3800, 32'h4001_4800,
    32'h4001_4c00, 32'h4002_2000, 32'h4002_3000, 32'h4800_0000,
    32'h4800_0400};
  localparam int SLOT_SLV [NSLOT] = '{
    S_APB1, S_APB1, S_APB1, S_APB2, S_APB2, S_APB3, S_APB3, S_APB3,
    S_APB3, S_APB3, S_APB3, S_APB4, S_APB4, S_FLASHCTL, S_CRC, S_PORT_A,
    S_PORT_B};
  localparam logic [31:0] PORT_C_BASE = 32'h4800_0800;
  // register offsets inside a slot that accept narrow transfers
  localparam logic [9:0] PORT_ODR_OFS = 10'h014;
  localparam logic [9:0] CRC_DR_OFS = 10'h000;

  // ==========================================
  // bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [3:0] LANE_BYTE = 4'h1;
  localparam logic [3:0] LANE_HALF = 4'h3;
  localparam logic [3:0] LANE_WORD = 4'hf;

  typedef enum logic [1:0] {
    ERR_IDLE = 2'h0,
    ERR_FIRST = 2'h1,
    ERR_SECOND = 2'h3
  } sad_err_state_type;

  typedef enum logic [2:0] {
    FK_RW = 3'h0,
    FK_WO = 3'h1,
    FK_CLR = 3'h2,
    FK_SET = 3'h3,
    FK_RLSET = 3'h4,
    FK_RHCLR = 3'h5
  } sad_field_kind_type;

  // ==========================================
  // helpers
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic slot_hit(input logic [31:0] a, input logic [31:0] base);
    slot_hit = a[31:SLOT_LSB] == base[31:SLOT_LSB];
  endfunction : slot_hit

  // byte k of a word rides lane k (little endian)
  function automatic logic [3:0] lane_mask(input logic [1:0] ofs, input logic [2:0] size);
    logic [3:0] m;
    m = LANE_WORD;
    if (size == HSIZE_BYTE)
      m = LANE_BYTE << ofs;
    else if (size == HSIZE_HALF)
      m = LANE_HALF << {ofs[1], 1'b0};
    lane_mask = m;
  endfunction : lane_mask

  // write effect of a field of the given kind
  function automatic logic [31:0] field_next(input sad_field_kind_type k, input logic [31:0] q,
                                             input logic [31:0] w);
    logic [31:0] n;
    n = w;
    if (k == FK_CLR || k == FK_RHCLR)
      n = q & w;
    else if (k == FK_SET || k == FK_RLSET)
      n = q | w;
    field_next = n;
  endfunction : field_next

  // read view of a field of the given kind
  function automatic logic [31:0] field_read(input sad_field_kind_type k, input logic [31:0] q);
    logic [31:0] r;
    r = q;
    if (k == FK_WO || k == FK_RLSET)
      r = '0;
    else if (k == FK_RHCLR)
      r = '1;
    field_read = r;
  endfunction : field_read
endpackage : sad_pkg
`default_nettype wire

// ===== sad_lane_steer.sv
// byte lane strobes for the data phase
`default_nettype none
module sad_lane_steer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // address phase
  input wire logic take_i,
  input wire logic [1:0] ofs_i,
  input wire logic [2:0] size_i,
  // data phase
  output logic [3:0] strb_o
);
  logic [3:0] strb_d;
  logic [3:0] strb_q;

  // ==========================================
  // lane register
  always_comb
  begin
    strb_d = strb_q;
    if (take_i)
      strb_d = sad_pkg::lane_mask(ofs_i, size_i);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      strb_q <= 4'h0;
    else
      strb_q <= strb_d;
  end

  assign strb_o = strb_q;

  AST_LANE_ORDER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (take_i && size_i == sad_pkg::HSIZE_BYTE) |=> strb_o == (4'h1 << $past(ofs_i)))
    else $error("byte lane does not follow address offset");
endmodule : sad_lane_steer
`default_nettype wire

// ===== sad_err_resp.sv
// two-cycle error response for unmapped or refused transfers
`default_nettype none
module sad_err_resp (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // request
  input wire logic err_take_i,
  // response
  output logic busy_o,
  output logic ready_o,
  output logic resp_o
);
  sad_pkg::sad_err_state_type st_d;
  sad_pkg::sad_err_state_type st_q;

  // ==========================================
  // state
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      sad_pkg::ERR_IDLE:
        if (err_take_i)
          st_d = sad_pkg::ERR_FIRST;
      sad_pkg::ERR_FIRST:
        st_d = sad_pkg::ERR_SECOND;
      sad_pkg::ERR_SECOND:
        st_d = err_take_i ? sad_pkg::ERR_FIRST : sad_pkg::ERR_IDLE;
      default:
        st_d = sad_pkg::ERR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_q <= sad_pkg::ERR_IDLE;
    else
      st_q <= st_d;
  end

  // first cycle stalls, second completes
  assign busy_o = st_q != sad_pkg::ERR_IDLE;
  assign ready_o = st_q != sad_pkg::ERR_FIRST;
  assign resp_o = busy_o;
endmodule : sad_err_resp
`default_nettype wire

// ===== sad_decoder.sv
// system address decoder and single-master bus matrix
`default_nettype none
module sad_decoder (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // master address and data phase
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic [2:0] hsize_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hready_o,
  output logic hresp_o,
  // slave selects
  output logic [sad_pkg::NSLV-1:0] hsel_o,
  output logic [sad_pkg::NAPB-1:0] apb_dev_sel_o,
  output logic otp_region_o,
  output logic [3:0] hstrb_o,
  // slave answers
  input wire logic [sad_pkg::NSLV-1:0][31:0] slv_hrdata_i,
  input wire logic [sad_pkg::NSLV-1:0] slv_hreadyout_i,
  input wire logic [sad_pkg::NSLV-1:0] slv_hresp_i
);
  logic [sad_pkg::NSLV-1:0] sel_a;
  logic [sad_pkg::NAPB-1:0] apb_a;
  logic narrow_ok;
  logic narrow;
  logic active;
  logic take;
  logic err_a;
  logic otp_a;
  logic [9:0] slot_ofs;
  logic [sad_pkg::NSLV-1:0] dsel_d;
  logic [sad_pkg::NSLV-1:0] dsel_q;
  logic err_busy;
  logic err_ready;
  logic err_resp;

  // ==========================================
  // address phase decode
  assign slot_ofs = haddr_i[9:0];

  always_comb
  begin
    sel_a = '0;
    apb_a = '0;
    if (sad_pkg::in_range(haddr_i, sad_pkg::FLASH_BASE, sad_pkg::FLASH_LAST))
      sel_a[sad_pkg::S_FLASH] = 1'b1;
    if (sad_pkg::in_range(haddr_i, sad_pkg::BOOT_BASE, sad_pkg::BOOT_LAST))
      sel_a[sad_pkg::S_BOOT] = 1'b1;
    if (sad_pkg::in_range(haddr_i, sad_pkg::SRAM_BASE, sad_pkg::SRAM_LAST))
      sel_a[sad_pkg::S_SRAM] = 1'b1;
    if (sad_pkg::in_range(haddr_i, sad_pkg::CORE_BASE, sad_pkg::CORE_LAST))
      sel_a[sad_pkg::S_CORE] = 1'b1;
    for (int i = 0; i < sad_pkg::NSLOT; i++)
    begin
      if (sad_pkg::slot_hit(haddr_i, sad_pkg::SLOT_BASE[i]))
      begin
        sel_a[sad_pkg::SLOT_SLV[i]] = 1'b1;
      end
    end
    for (int i = 0; i < sad_pkg::NAPB; i++)
      if (sad_pkg::slot_hit(haddr_i, sad_pkg::SLOT_BASE[i]))
        apb_a[i] = 1'b1;
    if (sad_pkg::slot_hit(haddr_i, sad_pkg::PORT_C_BASE))
      sel_a[sad_pkg::S_PORT_C] = 1'b1;
  end

  assign otp_a = sad_pkg::in_range(haddr_i, sad_pkg::OTP_BASE, sad_pkg::OTP_LAST);

  // ==========================================
  // transfer qualification
  assign active = htrans_i == sad_pkg::HTRANS_NONSEQ || htrans_i == sad_pkg::HTRANS_SEQ;
  assign take = active && hready_o;
  assign narrow = hsize_i != sad_pkg::HSIZE_WORD;

  always_comb
  begin
    narrow_ok = sel_a[sad_pkg::S_FLASH] || sel_a[sad_pkg::S_BOOT] || sel_a[sad_pkg::S_SRAM] ||
                sel_a[sad_pkg::S_CORE];
    if (sel_a[sad_pkg::S_CRC] && slot_ofs == sad_pkg::CRC_DR_OFS)
      narrow_ok = 1'b1;
    if ((sel_a[sad_pkg::S_PORT_A] || sel_a[sad_pkg::S_PORT_B] || sel_a[sad_pkg::S_PORT_C]) &&
        slot_ofs == sad_pkg::PORT_ODR_OFS)
      narrow_ok = 1'b1;
  end

  assign err_a = (sel_a == '0) || (narrow && !narrow_ok) || (hsize_i > sad_pkg::HSIZE_WORD);

  assign hsel_o = err_a ? '0 : sel_a;
  assign apb_dev_sel_o = err_a ? '0 : apb_a;
  assign otp_region_o = otp_a && !err_a;

  // ==========================================
  // data phase tracking
  always_comb
  begin
    dsel_d = dsel_q;
    if (hready_o)
      dsel_d = take ? hsel_o : '0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dsel_q <= '0;
    else
      dsel_q <= dsel_d;
  end

  sad_err_resp u_err (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .err_take_i(take && err_a),
    .busy_o(err_busy),
    .ready_o(err_ready),
    .resp_o(err_resp)
  );

  sad_lane_steer u_lanes (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .take_i(take && !err_a),
    .ofs_i(haddr_i[1:0]),
    .size_i(hsize_i),
    .strb_o(hstrb_o)
  );

  // ==========================================
  // response mux
  // one master, many slaves
  always_comb
  begin
    hrdata_o = '0;
    hready_o = 1'b1;
    hresp_o = 1'b0;
    if (err_busy)
    begin
      hready_o = err_ready;
      hresp_o = err_resp;
    end
    else
    begin
      for (int i = 0; i < sad_pkg::NSLV; i++)
      begin
        if (dsel_q[i])
        begin
          hrdata_o = slv_hrdata_i[i];
          hready_o = slv_hreadyout_i[i];
          hresp_o = slv_hresp_i[i];
        end
      end
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence err_taken;
    take && err_a && !hwrite_i || take && err_a && hwrite_i;
  endsequence
  sequence err_pair;
    (!hready_o && hresp_o) ##1 (hready_o && hresp_o);
  endsequence

  AST_ONE_SELECT: assert property ($onehot0(hsel_o))
    else $error("more than one slave selected");
  AST_FLASH_MAP: assert property ((haddr_i <= 32'h0000_4fff && hsize_i <= 3'h2) |-> hsel_o[0])
    else $error("flash address not routed to flash");
  AST_BOOT_MAP: assert property ((haddr_i[31:12] == 20'h00100 && haddr_i[11:0] <= 12'h9ff && hsize_i <= 3'h2)
    |-> hsel_o[1])
    else $error("boot address not routed to boot memory");
  AST_OTP_INSIDE: assert property (otp_region_o |-> hsel_o[1])
    else $error("otp flag outside boot select");
  AST_SRAM_MAP: assert property ((hsel_o[2]) |-> (haddr_i[31:12] == 20'h20000 && haddr_i[11:10] != 2'h3))
    else $error("sram selected outside its range");
  AST_CORE_MAP: assert property (hsel_o[12] |-> haddr_i[31:20] == 12'he00)
    else $error("core window selected outside 1MB");
  AST_APB_BRIDGE: assert property ((|apb_dev_sel_o) |-> (|hsel_o[6:3]))
    else $error("apb device without bridge select");
  AST_ERR_RESPONSE: assert property (err_taken |=> err_pair)
    else $error("error response not two cycles");
  AST_NARROW_REFUSED: assert property ((active && hsel_o[8] == 1'b0 && haddr_i[31:28] == 4'h4 &&
    hsize_i == 3'h0 && haddr_i[9:0] != 10'h014) |-> hsel_o == '0)
    else $error("narrow peripheral access not refused");
  AST_CLEAR_ONLY: assert property ((sad_pkg::field_next(sad_pkg::FK_CLR, hrdata_o, hwdata_i) & ~hrdata_o) == '0)
    else $error("clear-only field was set");
  AST_SET_ONLY: assert property ((~sad_pkg::field_next(sad_pkg::FK_SET, hrdata_o, hwdata_i) & hrdata_o) == '0)
    else $error("set-only field was cleared");
  AST_READ_VIEWS: assert property (sad_pkg::field_read(sad_pkg::FK_WO, hwdata_i) == '0 &&
    sad_pkg::field_read(sad_pkg::FK_RLSET, hwdata_i) == '0 &&
    sad_pkg::field_read(sad_pkg::FK_RHCLR, hwdata_i) == '1)
    else $error("field read view wrong");
  AST_HIDDEN_KINDS: assert property (
    (sad_pkg::field_next(sad_pkg::FK_RLSET, 32'h0, hwdata_i) == hwdata_i) &&
    (sad_pkg::field_next(sad_pkg::FK_RHCLR, 32'hffff_ffff, hwdata_i) == hwdata_i))
    else $error("hidden field write effect wrong");

  // ==========================================
  // slot and region checks
  // bridge one slots
  AST_BRIDGE_ONE_MAP: assert property ((hsize_i == 3'h2 &&
    haddr_i[31:10] inside {22'h10_0001, 22'h10_000b, 22'h10_000c}) |-> hsel_o == 13'h0008)
    else $error("bridge one slot not routed");
  AST_BRIDGE_TWO_MAP: assert property ((hsize_i == 3'h2 &&
    haddr_i[31:10] inside {22'h10_0011, 22'h10_0015}) |-> hsel_o == 13'h0010)
    else $error("bridge two slot not routed");
  AST_BRIDGE_THREE_MAP: assert property ((hsize_i == 3'h2 &&
    haddr_i[31:10] inside {22'h10_0040, 22'h10_0049, 22'h10_004a}) |-> hsel_o == 13'h0020)
    else $error("bridge three slot not routed");
  AST_BRIDGE_THREE_MORE: assert property ((hsize_i == 3'h2 &&
    haddr_i[31:10] inside {22'h10_004b, 22'h10_004c, 22'h10_004e}) |-> hsel_o == 13'h0020)
    else $error("bridge three upper slot not routed");
  AST_BRIDGE_FOUR_MAP: assert property ((hsize_i == 3'h2 &&
    haddr_i[31:10] inside {22'h10_0052, 22'h10_0053}) |-> hsel_o == 13'h0040)
    else $error("bridge four slot not routed");
  AST_FLASH_CTL_MAP: assert property ((hsize_i == 3'h2 && haddr_i[31:10] == 22'h10_0088)
    |-> hsel_o == 13'h0080)
    else $error("flash controller slot not routed");
  AST_CRC_MAP: assert property ((hsize_i == 3'h2 && haddr_i[31:10] == 22'h10_008c)
    |-> hsel_o == 13'h0100)
    else $error("crc slot not routed");
  AST_PORT_MAP: assert property ((hsize_i == 3'h2 &&
    haddr_i[31:10] inside {22'h12_0000, 22'h12_0001, 22'h12_0002}) |-> hsel_o == (13'h0200 << haddr_i[11:10]))
    else $error("port slot not routed");
  AST_SIZE_REFUSED: assert property ((hsize_i > 3'h2) |-> (hsel_o == '0 && apb_dev_sel_o == '0))
    else $error("oversized transfer selected a slave");
  AST_RESERVED_EMPTY: assert property ((haddr_i inside {[32'h0000_5000:32'h000f_ffff],
    [32'h0010_0a00:32'h1fff_ffff], [32'h2000_0c00:32'h3fff_ffff],
    [32'he010_0000:32'hffff_ffff]}) |-> hsel_o == '0)
    else $error("reserved address selected a slave");
  AST_OTP_MAP: assert property ((hsize_i <= 3'h2 && haddr_i >= 32'h0010_0770 &&
    haddr_i <= 32'h0010_0785) |-> otp_region_o)
    else $error("otp address not flagged");
  AST_ERR_NO_DATA: assert property (err_taken |=> (hrdata_o == '0) ##1 (hrdata_o == '0))
    else $error("read data shown during error response");
  AST_PORT_NARROW_OK: assert property ((hsize_i == 3'h0 && haddr_i[31:12] == 20'h48000 &&
    haddr_i[11:10] != 2'h3 && haddr_i[9:0] == 10'h014) |-> hsel_o != '0)
    else $error("byte access to port data register refused");
endmodule : sad_decoder
`default_nettype wire

// ===== sad_core_model.sv
// processor core model: sole ahb-lite master of the decoder
`default_nettype none
module sad_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // response
  input wire logic hready_i,
  input wire logic hresp_i,
  input wire logic [31:0] hrdata_i,
  // request
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic [2:0] hsize_o,
  output logic hwrite_o,
  output logic [31:0] hwdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rdy_q;
  logic er_q;
  logic [31:0] rd_q;
  initial
  begin
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hsize_o = sad_pkg::HSIZE_WORD;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0;
  end
  // answer as seen at the edge itself
  always @(posedge clk_i)
  begin
    rdy_q <= hready_i & rst_n_i;
    er_q <= hresp_i;
    rd_q <= hrdata_i;
  end
  task automatic put(input logic [31:0] a, input logic [2:0] sz);
    @(negedge clk_i);
    haddr_o = a;
    hsize_o = sz;
  endtask : put
  // request held until taken with ready high
  task automatic req(input logic [31:0] a, input logic [2:0] sz);
    put(a, sz);
    hwrite_o = 1'b0;
    htrans_o = sad_pkg::HTRANS_NONSEQ;
    do
    begin
      @(posedge clk_i);
      #1;
    end
    while (rdy_q !== 1'b1);
    @(negedge clk_i);
    htrans_o = 2'h0;
    haddr_o = ~a;
    hwdata_o = ~hwdata_o;
  endtask : req
  // data phase ends at the ready edge
  task automatic rsp(output logic [31:0] rd, output logic er);
    do
    begin
      @(posedge clk_i);
      #1;
    end
    while (rdy_q !== 1'b1);
    rd = rd_q;
    er = er_q;
  endtask : rsp
endmodule : sad_core_model
`default_nettype wire

// ===== sad_decoder_bench.sv
// testbench for the system address decoder
`default_nettype none
module sad_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i;
  logic rst_n_i;
  logic [31:0] haddr, hwdata, hrdata_o;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hwrite, hready_o, hresp_o, otp_region_o;
  logic [sad_pkg::NSLV-1:0] hsel_o, slv_rdy, slv_err;
  logic [sad_pkg::NAPB-1:0] apb_dev_sel_o;
  logic [3:0] hstrb_o;
  logic [sad_pkg::NSLV-1:0][31:0] slv_rd;
  int fails, total_checks, cyc, t0;
  localparam logic [31:0] MEM_A [10] = '{32'h0, 32'h4fff, 32'h10_0000, 32'h10_09ff, 32'h2000_0000,
    32'h2000_0bff, 32'he000_0000, 32'he00f_ffff, 32'h4800_0800, 32'h4800_0bff};
  localparam int MEM_S [10] = '{0, 0, 1, 1, 2, 2, 12, 12, 11, 11};
  localparam logic [31:0] RES_A [8] = '{32'h5000, 32'h10_0a00, 32'h2000_0c00, 32'h4000_0000,
    32'h4000_0800, 32'h4001_5000, 32'h4800_0c00, 32'he010_0000};

  sad_decoder sad_decoder_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .haddr_i(haddr), .htrans_i(htrans),
    .hsize_i(hsize), .hwrite_i(hwrite), .hwdata_i(hwdata), .hrdata_o(hrdata_o), .hready_o(hready_o),
    .hresp_o(hresp_o), .hsel_o(hsel_o), .apb_dev_sel_o(apb_dev_sel_o), .otp_region_o(otp_region_o),
    .hstrb_o(hstrb_o), .slv_hrdata_i(slv_rd), .slv_hreadyout_i(slv_rdy), .slv_hresp_i(slv_err));
  sad_core_model sad_core_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .hready_i(hready_o),
    .hresp_i(hresp_o), .hrdata_i(hrdata_o), .haddr_o(haddr), .htrans_o(htrans), .hsize_o(hsize),
    .hwrite_o(hwrite), .hwdata_o(hwdata));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic dec(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] s, input logic [31:0] p);
    sad_core_model_inst.put(a, sz);
    #1;
    chk(hsel_o, s);
    chk(apb_dev_sel_o, p);
  endtask : dec
  task automatic xfer(input logic [31:0] a, input logic [2:0] sz, input logic er, input logic [3:0] strb,
                      input int s);
    logic [31:0] rd;
    logic e;
    sad_core_model_inst.req(a, sz);
    if (er)
      chk({hready_o, hresp_o}, 2'h1);
    else
      chk(hstrb_o, strb);
    sad_core_model_inst.rsp(rd, e);
    chk(e, er);
    chk(rd, er ? 32'h0 : slv_rd[s]);
  endtask : xfer

  task automatic test_map();
    for (int i = 0; i < 10; i++)
      dec(MEM_A[i], sad_pkg::HSIZE_WORD, 32'h1 << MEM_S[i], 32'h0);
    for (int i = 0; i < sad_pkg::NSLOT; i++)
      for (int k = 0; k < 2; k++)
        dec(sad_pkg::SLOT_BASE[i] | (k * 32'h3ff), sad_pkg::HSIZE_WORD, 32'h1 << sad_pkg::SLOT_SLV[i],
            (i < 12) ? 32'h1 << i : 32'h0);
    for (int i = 0; i < 8; i++)
      dec(RES_A[i], sad_pkg::HSIZE_WORD, 32'h0, 32'h0);
    $display("test map done");
  endtask : test_map
  task automatic test_otp();
    logic [31:0] a [4];
    a = '{32'h10_076f, 32'h10_0770, 32'h10_0785, 32'h10_0786};
    for (int i = 0; i < 4; i++)
    begin
      sad_core_model_inst.put(a[i], sad_pkg::HSIZE_WORD);
      #1;
      chk({hsel_o[1], otp_region_o}, {1'b1, i == 1 || i == 2});
    end
    $display("test otp done");
  endtask : test_otp
  task automatic test_lanes();
    xfer(32'h2000_0000, sad_pkg::HSIZE_WORD, 1'b0, 4'hf, 2);
    for (int k = 0; k < 4; k++)
      xfer(32'h2000_0000 + k, sad_pkg::HSIZE_BYTE, 1'b0, 4'h1 << k, 2);
    xfer(32'h2000_0002, sad_pkg::HSIZE_HALF, 1'b0, 4'hc, 2);
    xfer(32'h0000_0000, sad_pkg::HSIZE_HALF, 1'b0, 4'h3, 0);
    xfer(32'h4800_0014, sad_pkg::HSIZE_BYTE, 1'b0, 4'h1, 9);
    xfer(32'h4002_3000, sad_pkg::HSIZE_BYTE, 1'b0, 4'h1, 8);
    $display("test lanes done");
  endtask : test_lanes
  task automatic test_refuse();
    for (int i = 0; i < 8; i += 3)
      xfer(RES_A[i], sad_pkg::HSIZE_WORD, 1'b1, 4'h0, 0);
    dec(32'h4000_0400, sad_pkg::HSIZE_BYTE, 32'h0, 32'h0);
    xfer(32'h4000_0400, sad_pkg::HSIZE_BYTE, 1'b1, 4'h0, 0);
    xfer(32'h4800_0000, sad_pkg::HSIZE_HALF, 1'b1, 4'h0, 0);
    xfer(32'h2000_0000, 3'h3, 1'b1, 4'h0, 0);
    xfer(32'h4001_3800, sad_pkg::HSIZE_WORD, 1'b0, 4'hf, 5);
    $display("test refuse done");
  endtask : test_refuse
  task automatic test_stall();
    logic [31:0] rd;
    logic e;
    @(negedge clk_i);
    slv_rdy[2] = 1'b0;
    sad_core_model_inst.req(32'h2000_0bfc, sad_pkg::HSIZE_WORD);
    t0 = cyc;
    chk(hready_o, 1'b0);
    fork
      begin
        repeat (3) @(negedge clk_i);
        slv_rdy[2] = 1'b1;
        slv_err[2] = 1'b1;
      end
    join_none
    sad_core_model_inst.rsp(rd, e);
    chk(cyc - t0, 32'h4);
    chk(e, 1'b1);
    chk(rd, slv_rd[2]);
    slv_err[2] = 1'b0;
    $display("test stall done");
  endtask : test_stall

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  initial
  begin
    fails = 0;
    total_checks = 0;
    cyc = 0;
    rst_n_i = 1'b0;
    slv_rdy = '1;
    slv_err = '0;
    for (int k = 0; k < sad_pkg::NSLV; k++)
      slv_rd[k] = 32'h5a3c_0000 | k;
    repeat (12) @(negedge clk_i);
    chk({hready_o, hresp_o, hstrb_o}, 6'h20);
    rst_n_i = 1'b1;
    test_map();
    test_otp();
    test_lanes();
    test_refuse();
    test_stall();
    final_report();
  end
endmodule : sad_decoder_bench
`default_nettype wire
